// ---- logic/ppd_irq.sv ----
`timescale 1ns/100ps
module ppd_irq
    import ppd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] event_in,
    input wire logic wr_enable,
    input wire logic wr_clear,
    input wire logic [7:0] wdata,
    output logic [7:0] status,
    output logic [7:0] enable,
    output logic irq
);

    logic [7:0] status_ff;
    logic [7:0] enable_ff;
    logic [7:0] nxt_status;

    // A new event wins over a clear in the same cycle
    assign nxt_status = (status_ff & ~(wr_clear ? wdata : IRQ_RST)) | event_in;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= IRQ_RST;
            enable_ff <= IRQ_RST;
        end else begin
            status_ff <= nxt_status;
            if (wr_enable) begin
                enable_ff <= wdata;
            end
        end
    end

    assign status = status_ff;
    assign enable = enable_ff;
    assign irq = |(status_ff & enable_ff);

endmodule : ppd_irq

// ---- logic/ppd_pkg.sv ----
package ppd_pkg;

    // Bus geometry
    localparam int APB_AW = 16;
    localparam int APB_DW = 32;

    // Port widths
    localparam int WIDE_W = 8;
    localparam int NARROW_W = 7;

    // Register indices; byte address is four times the index
    localparam logic [13:0] IDX_A_DATA = 14'h0000;
    localparam logic [13:0] IDX_B_DATA = 14'h0001;
    localparam logic [13:0] IDX_C_DATA = 14'h0002;
    localparam logic [13:0] IDX_D_DATA = 14'h0003;
    localparam logic [13:0] IDX_A_DIR = 14'h0004;
    localparam logic [13:0] IDX_B_DIR = 14'h0005;
    localparam logic [13:0] IDX_C_DIR = 14'h0006;
    localparam logic [13:0] IDX_D_DIR = 14'h0007;
    localparam logic [13:0] IDX_IRQ_STATUS = 14'h0010;
    localparam logic [13:0] IDX_IRQ_ENABLE = 14'h0011;
    localparam logic [13:0] IDX_IRQ_CLEAR = 14'h0012;
    localparam logic [13:0] IDX_B_OPTION = 14'h3ff0;

    // Fourth port sharing layout
    localparam int SCI_LSB = 0;
    localparam int SCI_W = 2;
    localparam int SPI_LSB = 2;
    localparam int SPI_W = 4;

    // Values after reset
    localparam logic [WIDE_W-1:0] DIR_RST = 8'h00;
    localparam logic [WIDE_W-1:0] PREV_PIN_RST = 8'hff;
    localparam logic [WIDE_W-1:0] OPT_RST = 8'h00;
    localparam logic [WIDE_W-1:0] IRQ_RST = 8'h00;
    localparam logic [APB_DW-1:0] RDATA_RST = 32'h0000_0000;

    // Index to byte address
    function automatic logic [APB_AW-1:0] ppd_addr(input logic [13:0] idx);
        ppd_addr = {idx, 2'b00};
    endfunction : ppd_addr

endpackage : ppd_pkg

// ---- logic/ppd_port.sv ----
`timescale 1ns/100ps
module ppd_port
    import ppd_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    ppd_port_if.port bus,
    input wire logic dir_lock,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe
);

    logic [W-1:0] dir_ff;
    logic [W-1:0] latch_ff;

    // Direction clears on reset so every pin comes up as input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_ff <= '0;
        end else if (bus.wr_dir && !dir_lock) begin
            dir_ff <= bus.wdata;
        end
    end

    // Data latch has no reset on purpose: its contents survive reset
    always_ff @(posedge pclk) begin
        if (bus.wr_data) begin
            latch_ff <= bus.wdata;
        end
    end

    // Lock also masks any direction left over from a mode change
    assign pin_oe = dir_ff & ~{W{dir_lock}};
    assign pin_out = latch_ff;
    assign bus.dir = pin_oe;
    assign bus.latch = latch_ff;
    assign bus.rd_data = (pin_oe & latch_ff) | (~pin_oe & pin_in);

endmodule : ppd_port

// ---- logic/ppd_port_if.sv ----
`timescale 1ns/100ps
interface ppd_port_if #(parameter int W = 8);
    logic wr_data;
    logic wr_dir;
    logic [W-1:0] wdata;
    logic [W-1:0] rd_data;
    logic [W-1:0] dir;
    logic [W-1:0] latch;

    modport ctrl (output wr_data, output wr_dir, output wdata,
                  input rd_data, input dir, input latch);
    modport port (input wr_data, input wr_dir, input wdata,
                  output rd_data, output dir, output latch);
endinterface : ppd_port_if

// ---- logic/ppd_top.sv ----
// How it works
// - Direction bit one drives the pin from its latch; zero leaves it input.
// - Reset clears every direction bit, so all pins become inputs.
// - Reset leaves data latches unchanged; power-up contents are undefined.
// - First port: data at index 0000, direction at index 0004.
// - Second port: data at index 0001, direction at index 0005.
// - Third port: data at index 0002, direction at index 0006.
// - Second port pin raises an interrupt only when its option bit allows.
// - Option enabled and pin an input switches on that pin's pull-up.
// - Second port interrupts follow the edge or edge-and-level sensitivity.
// - Fourth port is seven bits; input-only, direction locked, in compatibility.
// - Four fourth-port pins shared with SPI, two with SCI.
// - Reset disables serial drivers on the fourth port and clears direction.
// - Stop mode keeps pin levels and directions of the first three ports unchanged.
`timescale 1ns/100ps
module ppd_top
    import ppd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [APB_DW-1:0] pwdata,
    output logic [APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic compatibility_configuration,
    input wire logic stop_mode,
    input wire logic irq_level_sense,
    input wire logic [WIDE_W-1:0] option_strap,
    input wire logic [WIDE_W-1:0] pa_in,
    output logic [WIDE_W-1:0] pa_out,
    output logic [WIDE_W-1:0] pa_oe,
    input wire logic [WIDE_W-1:0] pb_in,
    output logic [WIDE_W-1:0] pb_out,
    output logic [WIDE_W-1:0] pb_oe,
    output logic [WIDE_W-1:0] pb_pullup_en,
    input wire logic [WIDE_W-1:0] pc_in,
    output logic [WIDE_W-1:0] pc_out,
    output logic [WIDE_W-1:0] pc_oe,
    input wire logic [NARROW_W-1:0] pd_in,
    output logic [NARROW_W-1:0] pd_out,
    output logic [NARROW_W-1:0] pd_oe,
    input wire logic [SPI_W-1:0] spi_out,
    input wire logic [SPI_W-1:0] spi_oe,
    input wire logic [SCI_W-1:0] sci_out,
    input wire logic [SCI_W-1:0] sci_oe,
    output logic port_irq
);

    // Hazards and limitations of this block:
    // - Data latches carry no reset, so output pins read back unknown until written.
    // - Software should load a latch before raising its direction bit,
    //   otherwise the pin briefly shows stale data.
    // - A pulled-up interrupt pin should have its latch set to one before it
    //   turns from input to output, or the drop from the pull-up to the old
    //   latch level may look like a falling edge.
    // - The interrupt option is a strap, not a register; it is sampled every
    //   clock after reset, so a change shows one cycle later.
    // - Stop mode drops every register write rather than halting the clock,
    //   so the first three ports' pins and directions hold while the bus stays alive.
    // - The fourth port lock masks the output enable at once; a direction
    //   written before the lock comes back when the lock is released.
    // - Read data is caught in the setup cycle; a pin that moves between
    //   setup and access is seen with its setup value.
    // - The slave never inserts wait states; unmapped or unaligned accesses
    //   answer with an error and read as zero.

    // Interfaces to the four port slices
    ppd_port_if #(.W(WIDE_W)) if_a ();
    ppd_port_if #(.W(WIDE_W)) if_b ();
    ppd_port_if #(.W(WIDE_W)) if_c ();
    ppd_port_if #(.W(NARROW_W)) if_d ();

    logic [APB_DW-1:0] prdata_ff;
    logic [WIDE_W-1:0] opt_ff;
    logic [WIDE_W-1:0] pb_prev_ff;
    logic serial_live_ff;

    logic setup;
    logic access;
    logic wr_go;
    logic hit_a_data;
    logic hit_b_data;
    logic hit_c_data;
    logic hit_d_data;
    logic hit_a_dir;
    logic hit_b_dir;
    logic hit_c_dir;
    logic hit_d_dir;
    logic hit_status;
    logic hit_enable;
    logic hit_clear;
    logic hit_option;
    logic [SPI_W-1:0] spi_drv;
    logic [SCI_W-1:0] sci_drv;
    logic mapped;
    logic [APB_DW-1:0] rd_mux;
    logic [WIDE_W-1:0] irq_status;
    logic [WIDE_W-1:0] irq_enable;
    logic [WIDE_W-1:0] pb_event;
    logic [WIDE_W-1:0] pb_fall;
    logic [WIDE_W-1:0] pb_low;
    logic [NARROW_W-1:0] pd_port_out;
    logic [NARROW_W-1:0] pd_port_oe;
    logic [NARROW_W-1:0] serial_drv;
    logic [NARROW_W-1:0] serial_val;

    // Register map, one aligned word each, byte address four times index:
    //   first port data 0x0000, direction 0x0004
    //   second port data 0x0001, direction 0x0005
    //   third port data 0x0002, direction 0x0006
    //   fourth port data 0x0003, direction 0x0007
    //   interrupt status 0x0010, read only, sticky
    //   interrupt enable 0x0011, read and write
    //   interrupt clear 0x0012, write one to clear, reads zero
    //   second port interrupt option 0x3ff0, read only strap
    // Only the low eight bits of a word carry data; upper bits read zero.
    // Writes to read-only words are dropped quietly, with no error.

    // Full word match; a misaligned address never hits, so it errors
    function automatic logic ppd_hit(input logic [APB_AW-1:0] addr, input logic [13:0] want);
        ppd_hit = (addr == ppd_addr(want));
    endfunction : ppd_hit

    // Address decode: one aligned word per register
    assign hit_a_data = ppd_hit(paddr, IDX_A_DATA);
    assign hit_a_dir = ppd_hit(paddr, IDX_A_DIR);
    assign hit_b_data = ppd_hit(paddr, IDX_B_DATA);
    assign hit_b_dir = ppd_hit(paddr, IDX_B_DIR);
    assign hit_c_data = ppd_hit(paddr, IDX_C_DATA);
    assign hit_c_dir = ppd_hit(paddr, IDX_C_DIR);
    assign hit_d_data = ppd_hit(paddr, IDX_D_DATA);
    assign hit_d_dir = ppd_hit(paddr, IDX_D_DIR);
    assign hit_status = ppd_hit(paddr, IDX_IRQ_STATUS);
    assign hit_enable = ppd_hit(paddr, IDX_IRQ_ENABLE);
    assign hit_clear = ppd_hit(paddr, IDX_IRQ_CLEAR);
    assign hit_option = ppd_hit(paddr, IDX_B_OPTION);
    assign mapped = hit_a_data | hit_b_data | hit_c_data | hit_d_data
                  | hit_a_dir | hit_b_dir | hit_c_dir | hit_d_dir
                  | hit_status | hit_enable | hit_clear | hit_option;

    // APB phases; the slave never stalls
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // Writes freeze in stop mode so pins keep their level and direction
    assign wr_go = access && pwrite && mapped && !stop_mode;

    // Write strobes into the port slices
    assign if_a.wr_data = wr_go && hit_a_data;
    assign if_a.wr_dir = wr_go && hit_a_dir;
    assign if_a.wdata = pwdata[WIDE_W-1:0];
    assign if_b.wr_data = wr_go && hit_b_data;
    assign if_b.wr_dir = wr_go && hit_b_dir;
    assign if_b.wdata = pwdata[WIDE_W-1:0];
    assign if_c.wr_data = wr_go && hit_c_data;
    assign if_c.wr_dir = wr_go && hit_c_dir;
    assign if_c.wdata = pwdata[WIDE_W-1:0];
    assign if_d.wr_data = wr_go && hit_d_data;
    assign if_d.wr_dir = wr_go && hit_d_dir;
    assign if_d.wdata = pwdata[NARROW_W-1:0];

    // Port slices
    ppd_port #(.W(WIDE_W)) u_port_a (
        .pclk(pclk),
        .presetn(presetn),
        .bus(if_a.port),
        .dir_lock(1'b0),
        .pin_in(pa_in),
        .pin_out(pa_out),
        .pin_oe(pa_oe)
    );

    ppd_port #(.W(WIDE_W)) u_port_b (
        .pclk(pclk),
        .presetn(presetn),
        .bus(if_b.port),
        .dir_lock(1'b0),
        .pin_in(pb_in),
        .pin_out(pb_out),
        .pin_oe(pb_oe)
    );

    ppd_port #(.W(WIDE_W)) u_port_c (
        .pclk(pclk),
        .presetn(presetn),
        .bus(if_c.port),
        .dir_lock(1'b0),
        .pin_in(pc_in),
        .pin_out(pc_out),
        .pin_oe(pc_oe)
    );

    // Fourth port is locked to input in the compatibility configuration
    ppd_port #(.W(NARROW_W)) u_port_d (
        .pclk(pclk),
        .presetn(presetn),
        .bus(if_d.port),
        .dir_lock(compatibility_configuration),
        .pin_in(pd_in),
        .pin_out(pd_port_out),
        .pin_oe(pd_port_oe)
    );

    // Serial units take over their pins only once reset has released
    // Gating per unit keeps the drivers off through reset and one edge after
    assign spi_drv = spi_oe & {SPI_W{serial_live_ff}};
    assign sci_drv = sci_oe & {SCI_W{serial_live_ff}};
    // Top pin of the fourth port is never shared
    assign serial_drv = {1'b0, spi_drv, sci_drv};
    assign serial_val = {1'b0, spi_out, sci_out};
    assign pd_oe = pd_port_oe | serial_drv;
    assign pd_out = (serial_drv & serial_val) | (~serial_drv & pd_port_out);

    // Pull-ups on second port where the option is on and the pin is input
    assign pb_pullup_en = opt_ff & ~pb_oe;

    // Events: falling edge always, low level too when level sense is on
    assign pb_fall = pb_prev_ff & ~pb_in;
    assign pb_low = ~pb_in & {WIDE_W{irq_level_sense}};
    assign pb_event = opt_ff & (pb_fall | pb_low);

    ppd_irq u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .event_in(pb_event),
        .wr_enable(wr_go && hit_enable),
        .wr_clear(wr_go && hit_clear),
        .wdata(pwdata[WIDE_W-1:0]),
        .status(irq_status),
        .enable(irq_enable),
        .irq(port_irq)
    );

    // Read selection; the clear register reads as zero
    always_comb begin
        rd_mux = RDATA_RST;
        case (1'b1)
            hit_a_data: rd_mux[WIDE_W-1:0] = if_a.rd_data;
            hit_b_data: rd_mux[WIDE_W-1:0] = if_b.rd_data;
            hit_c_data: rd_mux[WIDE_W-1:0] = if_c.rd_data;
            hit_d_data: rd_mux[NARROW_W-1:0] = if_d.rd_data;
            hit_a_dir: rd_mux[WIDE_W-1:0] = if_a.dir;
            hit_b_dir: rd_mux[WIDE_W-1:0] = if_b.dir;
            hit_c_dir: rd_mux[WIDE_W-1:0] = if_c.dir;
            hit_d_dir: rd_mux[NARROW_W-1:0] = if_d.dir;
            hit_status: rd_mux[WIDE_W-1:0] = irq_status;
            hit_enable: rd_mux[WIDE_W-1:0] = irq_enable;
            hit_option: rd_mux[WIDE_W-1:0] = opt_ff;
            default: rd_mux = RDATA_RST;
        endcase
    end

    // Read data caught in the setup cycle, steady through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= RDATA_RST;
        end else if (setup && !pwrite) begin
            prdata_ff <= rd_mux;
        end
    end
    assign prdata = prdata_ff;

    // Option strap is sampled after release, never under reset;
    // pull-ups and interrupts therefore stay off while reset is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_ff <= OPT_RST;
        end else begin
            opt_ff <= option_strap;
        end
    end

    // Previous pin level; reset to the idle high level so that no
    // false falling edge is seen on the first edge after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pb_prev_ff <= PREV_PIN_RST;
        end else begin
            pb_prev_ff <= pb_in;
        end
    end

    // Serial units may drive only from the first edge after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_live_ff <= 1'b0;
        end else begin
            serial_live_ff <= 1'b1;
        end
    end

endmodule : ppd_top

// ---- test/ppd_board.sv ----
`timescale 1ns/100ps
module ppd_board
    import ppd_pkg::*;
(
    input wire logic pclk,
    input wire logic [WIDE_W-1:0] pa_out,
    input wire logic [WIDE_W-1:0] pa_oe,
    input wire logic [WIDE_W-1:0] pb_out,
    input wire logic [WIDE_W-1:0] pb_oe,
    input wire logic [WIDE_W-1:0] pb_pullup_en,
    input wire logic [WIDE_W-1:0] pc_out,
    input wire logic [WIDE_W-1:0] pc_oe,
    input wire logic [NARROW_W-1:0] pd_out,
    input wire logic [NARROW_W-1:0] pd_oe,
    input wire logic [WIDE_W-1:0] ext_a,
    input wire logic [WIDE_W-1:0] ext_b,
    input wire logic [WIDE_W-1:0] rel_b,
    input wire logic [WIDE_W-1:0] ext_c,
    input wire logic [NARROW_W-1:0] ext_d,
    output logic [WIDE_W-1:0] pa_in,
    output logic [WIDE_W-1:0] pb_in,
    output logic [WIDE_W-1:0] pc_in,
    output logic [NARROW_W-1:0] pd_in
);
    logic [WIDE_W-1:0] wander = 8'h55;
    logic [WIDE_W-1:0] pb_free;
    // A floating line wanders, so an unpulled read never looks stable
    always @(posedge pclk) begin
        wander <= ~wander;
    end
    // Own drive wins; released second-port lines stay high only with pull-up
    assign pb_free = pb_pullup_en | wander;
    assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_a);
    assign pb_in = (pb_oe & pb_out) | (~pb_oe & ((rel_b & pb_free) | (~rel_b & ext_b)));
    assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext_c);
    assign pd_in = (pd_oe & pd_out) | (~pd_oe & ext_d);
endmodule : ppd_board

// ---- test/ppd_tb_top.sv ----
`timescale 1ns/100ps
module ppd_tb_top;
    import ppd_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = 16'h0000;
    logic [APB_DW-1:0] pwdata = 32'h0000_0000;
    logic compatibility_configuration = 1'b0;
    logic stop_mode = 1'b0;
    logic irq_level_sense = 1'b0;
    logic [WIDE_W-1:0] option_strap = 8'h0f;
    logic [WIDE_W-1:0] ext_a = 8'h3c;
    logic [WIDE_W-1:0] ext_b = 8'h10;
    logic [WIDE_W-1:0] rel_b = 8'h0f;
    logic [WIDE_W-1:0] ext_c = 8'hc3;
    logic [NARROW_W-1:0] ext_d = 7'h00;
    logic [SPI_W-1:0] spi_out = 4'h0;
    logic [SPI_W-1:0] spi_oe = 4'h0;
    logic [SCI_W-1:0] sci_out = 2'h0;
    logic [SCI_W-1:0] sci_oe = 2'h0;
    logic pready, pslverr, port_irq, err;
    logic [APB_DW-1:0] prdata, rd;
    logic [WIDE_W-1:0] pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, pb_pullup_en;
    logic [WIDE_W-1:0] pc_in, pc_out, pc_oe;
    logic [NARROW_W-1:0] pd_in, pd_out, pd_oe;
    int errors = 0;
    int num_checks = 0;
    // Rows: write flag, register index, write data or expected read
    logic [22:0] rows [16] = '{{1'b1, IDX_A_DATA, 8'h5a}, {1'b1, IDX_A_DIR, 8'hf0},
        {1'b0, IDX_A_DATA, 8'h5c}, {1'b0, IDX_A_DIR, 8'hf0}, {1'b1, IDX_C_DATA, 8'ha5},
        {1'b1, IDX_C_DIR, 8'h0f}, {1'b0, IDX_C_DATA, 8'hc5}, {1'b0, IDX_C_DIR, 8'h0f},
        {1'b1, IDX_B_DATA, 8'hff}, {1'b1, IDX_B_DIR, 8'h00}, {1'b0, IDX_B_DATA, 8'h1f},
        {1'b0, IDX_B_OPTION, 8'h0f}, {1'b1, IDX_D_DATA, 8'h00}, {1'b1, IDX_D_DIR, 8'h7f},
        {1'b0, IDX_D_DIR, 8'h7f}, {1'b0, 14'h0020, 8'h00}};

    ppd_top uut (.*);
    ppd_board board (.*);

    // Free-running bus clock
    always #2 pclk = ~pclk;

    task conclude;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // One transfer; request held until pready is seen high at an edge
    task apb(input logic w, input logic [13:0] idx, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Data written before direction, so outputs come up clean
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            apb(rows[k][22], rows[k][21:8], {24'h00_0000, rows[k][7:0]});
            if (!rows[k][22]) cmp(rd, {24'h00_0000, rows[k][7:0]});
        end
        cmp({31'h0000_0000, err}, 1);
        @(posedge pclk);
        cmp(pa_oe, 8'hf0);
        cmp(pa_out, 8'h5a);
        cmp(pc_out, 8'ha5);
        cmp(pb_oe, 8'h00);
        cmp(pb_out, 8'hff);
        cmp(pb_pullup_en, 8'h0f);
        cmp(pready, 1);
        $display("register rows done");
        // Optioned bit 0 and plain bit 4 fall together
        apb(1'b1, IDX_IRQ_CLEAR, 32'h0000_00ff);
        apb(1'b1, IDX_IRQ_ENABLE, 32'h0000_0001);
        ext_b <= 8'h00;
        rel_b <= 8'h0e;
        repeat (3) @(posedge pclk);
        cmp(port_irq, 1);
        apb(1'b0, IDX_IRQ_STATUS, 32'h0000_0000);
        cmp(rd, 1);
        apb(1'b1, IDX_IRQ_ENABLE, 32'h0000_0000);
        @(posedge pclk);
        cmp(port_irq, 0);
        apb(1'b1, IDX_IRQ_CLEAR, 32'h0000_0001);
        apb(1'b0, IDX_IRQ_STATUS, 32'h0000_0000);
        cmp(rd, 0);
        irq_level_sense <= 1'b1;
        apb(1'b1, IDX_IRQ_CLEAR, 32'h0000_0001);
        apb(1'b0, IDX_IRQ_STATUS, 32'h0000_0000);
        cmp(rd, 1);
        $display("interrupt test done");
        // Writes in stop mode must leave the pins alone
        stop_mode <= 1'b1;
        apb(1'b1, IDX_A_DIR, 32'h0000_0000);
        apb(1'b1, IDX_A_DATA, 32'h0000_0000);
        @(posedge pclk);
        cmp(pa_oe, 8'hf0);
        cmp(pa_out, 8'h5a);
        stop_mode <= 1'b0;
        $display("stop test done");
        // Compatibility locks direction; serial units own shared pins
        compatibility_configuration <= 1'b1;
        spi_oe <= 4'hf;
        spi_out <= 4'ha;
        sci_oe <= 2'h3;
        sci_out <= 2'h1;
        apb(1'b1, IDX_D_DIR, 32'h0000_0000);
        @(posedge pclk);
        cmp(pd_oe, 7'h3f);
        cmp(pd_out[5:0], 6'h29);
        compatibility_configuration <= 1'b0;
        sci_oe <= 2'h0;
        @(posedge pclk);
        @(posedge pclk);
        cmp(pd_oe, 7'h7f);
        $display("fourth port test done");
        // Reset mid-run: directions clear, latches survive
        presetn <= 1'b0;
        @(posedge pclk);
        cmp(pa_oe, 8'h00);
        cmp(pd_oe, 7'h00);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        spi_oe <= 4'h0;
        repeat (2) @(posedge pclk);
        cmp(pa_out, 8'h5a);
        cmp(pc_oe, 8'h00);
        cmp(pd_out, 7'h00);
        $display("reset test done");
        conclude();
    end
endmodule : ppd_tb_top

bind ppd_top ppd_props chk (.*);

// ---- test/ppd_top_properties.sv ----
`timescale 1ns/100ps
module ppd_props
    import ppd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [APB_DW-1:0] pwdata,
    input wire logic [APB_DW-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic compatibility_configuration,
    input wire logic stop_mode,
    input wire logic [WIDE_W-1:0] option_strap,
    input wire logic [WIDE_W-1:0] pa_in,
    input wire logic [WIDE_W-1:0] pa_out,
    input wire logic [WIDE_W-1:0] pa_oe,
    input wire logic [WIDE_W-1:0] pb_out,
    input wire logic [WIDE_W-1:0] pb_oe,
    input wire logic [WIDE_W-1:0] pb_pullup_en,
    input wire logic [WIDE_W-1:0] pc_out,
    input wire logic [WIDE_W-1:0] pc_oe,
    input wire logic [NARROW_W-1:0] pd_oe,
    input wire logic [SPI_W-1:0] spi_oe,
    input wire logic [SCI_W-1:0] sci_oe,
    input wire logic port_irq
);
    logic wr_go;
    logic [NARROW_W-1:0] ser_oe;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Write that the slave must take; stop mode drops writes
    assign wr_go = psel && penable && pwrite && !stop_mode;
    assign ser_oe = {1'b0, spi_oe, sci_oe};
    // Register and pin relations
    chk_dir_write: assert property (wr_go && paddr == 16'h0010 |=> pa_oe == $past(pwdata[7:0]))
        else $error("direction write not on pins");
    chk_data_write: assert property (wr_go && paddr == 16'h0000 |=> pa_out == $past(pwdata[7:0]))
        else $error("data write not on pins");
    chk_reset_dirs: assert property ($rose(presetn) |-> {pa_oe, pb_oe, pc_oe, pd_oe} == 31'h0)
        else $error("pin driven after reset");
    chk_pullup_gate: assert property ((pb_pullup_en & (pb_oe | ~option_strap)) == 8'h00)
        else $error("pull-up on without option or on output");
    chk_stop_hold: assert property (stop_mode |=> $stable({pa_oe, pa_out, pb_oe, pb_out, pc_oe, pc_out}))
        else $error("pins moved in stop mode");
    chk_compat_lock: assert property (compatibility_configuration |-> (pd_oe & ~ser_oe) == 7'h00)
        else $error("fourth port driven in compatibility");
    chk_serial_share: assert property ($past(presetn) |-> (pd_oe & ser_oe) == ser_oe)
        else $error("serial driver not on shared pin");
    chk_read_mux: assert property (psel && !penable && !pwrite && paddr == 16'h0000 |=>
        prdata == {24'h00_0000, ($past(pa_oe) & $past(pa_out)) | (~$past(pa_oe) & $past(pa_in))})
        else $error("data read mixes pins wrongly");
    chk_unmapped_err: assert property (psel && penable && paddr == 16'h0080 |-> pslverr && pready)
        else $error("unmapped access not refused");
    // Main scenarios seen
    cover property (port_irq);
    cover property (wr_go && paddr == 16'h0010);
    cover property (stop_mode && psel && penable);
endmodule : ppd_props
